// *** hw/fpc_core.sv ***
// Primary switch gating, current limit shaping and fault sequencing
// Function
// - Supply undervoltage disables the power switch
// - After undervoltage, wait for shunt clamp level
// - Latch standard or increased limit from capacitor
// - Supply overcurrent latches off or auto-restarts
// - Hysteretic thermal: off hot, on when cooled
// - Latching thermal clears on supply reset/line UV
// - Limit ramps down with off-time, applied at request
// - Limit floor at thirty percent of full
// - Limit jitters between full and ninety-five percent
// - Auto-restart holds switch off for off period
// - Overload request rate too long enters auto-restart
// - Request loss timeout enters auto-restart
// - Latch clears on supply reset or line UV
// - Two fast limit cycles skip twenty-five microseconds
// - Limit within 200 ns forces 30 us off
// - Repeat after forced off gives short-fault off
// - Rectifier short guard removable by build option
// - Power-up: charge, latch limit, then check line
// - Line brown-out timeout enters auto-restart
// - Line overvoltage enters auto-restart until normal
// - Off-time over 50 us disconnects line sense
//
// Implementation choices: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module fpc_core #(
  parameter int RESTART_ON_CYC = fpc_pkg::RESTART_ON_CYC,
  parameter int RESTART_OFF_CYC = 10000000,
  parameter int SHORT_OFF_CYC  = 20000000,
  parameter int REQ_LOSS_CYC   = 1000000,
  parameter int LINE_LOW_CYC   = 300000,
  parameter int JIT_HALF_CYC   = 800,
  parameter bit SRS_EN         = 1'b1
) (
  // Clock and reset
  input  wire logic                clk_sys_i,
  input  wire logic                rst_i,
  // Analog comparator results and secondary requests
  input  wire fpc_pkg::fpc_cmp_type cmp_i,
  // Power stage
  output logic                     switch_gate_o,
  output logic [7:0]               peak_current_limit_o,
  output logic                     limit_increased_o,
  output logic                     line_sense_on_o,
  // AHB-Lite slave
  input  wire logic                hsel_i,
  input  wire logic [31:0]         haddr_i,
  input  wire logic [1:0]          htrans_i,
  input  wire logic                hwrite_i,
  input  wire logic [2:0]          hsize_i,
  input  wire logic [31:0]         hwdata_i,
  input  wire logic                hready_i,
  output logic                     hreadyout_o,
  output logic                     hresp_o,
  output logic [31:0]              hrdata_o
);

  localparam logic [23:0] T_RON    = 24'(RESTART_ON_CYC);
  // Off periods need 25 bits so the long short-fault period is not cut
  localparam logic [24:0] T_ROFF   = 25'(RESTART_OFF_CYC);
  localparam logic [24:0] T_SHORT  = 25'(SHORT_OFF_CYC);
  localparam logic [23:0] T_LOSS   = 24'(REQ_LOSS_CYC);
  localparam logic [23:0] T_LLOW   = 24'(LINE_LOW_CYC);
  localparam logic [15:0] T_JIT    = 16'(JIT_HALF_CYC);
  localparam logic [23:0] T_OVL    = 24'(fpc_pkg::OVL_GAP_CYC);
  localparam logic [23:0] T_DISC   = 24'(fpc_pkg::LINE_DISC_CYC);
  localparam logic [15:0] T_SRS    = 16'(fpc_pkg::SRS_OFF_CYC);
  localparam logic [15:0] T_SKIP   = 16'(fpc_pkg::SOA_SKIP_CYC);
  localparam logic [7:0]  LEADING_EDGE_WINDOW    = 8'(fpc_pkg::LES_WIN_CYC);
  localparam logic [7:0]  T_SOA    = 8'(fpc_pkg::SOA_WIN_CYC);
  localparam logic [7:0]  T_MAXON  = 8'(fpc_pkg::MAX_ON_CYC);
  localparam logic [23:0] CNT_MAX  = 24'hffffff;

  typedef struct packed {
    fpc_pkg::fpc_state_type st;
    logic [2:0]  ctrl;
    logic [31:0] rdata;
    logic        d_wr;
    logic [7:0]  d_addr;
    logic        gate;
    logic        lim_sel;
    logic [7:0]  lim_level;
    logic        jit_lo;
    logic [15:0] jit_cnt;
    logic [7:0]  on_cnt;
    logic [23:0] off_cnt;
    logic [23:0] req_gap;
    logic [23:0] ovl_cnt;
    logic [24:0] tmr;
    logic [15:0] hold;
    logic        srs_armed;
    logic        soa_prev;
    logic        uv_block;
    logic        therm_block;
    logic        low_seen;
    logic [23:0] low_cnt;
    logic        req_prev;
    logic        line_on;
    logic [2:0]  cause;
  } fpc_core_state_type;

  fpc_core_state_type  r;
  fpc_core_state_type  next_r;
  fpc_pkg::fpc_cmp_type c;

  // ==========================================================
  // Comparator synchronisers
  fpc_sync #(
    .W($bits(fpc_pkg::fpc_cmp_type))
  ) u_sync (
    .clk_sys_i(clk_sys_i),
    .rst_i    (rst_i),
    .async_i  (cmp_i),
    .sync_o   (c)
  );

  // ==========================================================
  // Next-state logic
  logic        req_edge;
  logic        can_on;
  logic        ap_valid;
  logic [7:0]  lim_top;
  logic [23:0] drop;
  logic [7:0]  lim_now;
  logic [31:0] status;

  always_comb
  begin
    next_r   = r;
    req_edge = c.cycle_req && !r.req_prev;
    lim_top  = r.jit_lo ? fpc_pkg::LIM_JITTER : fpc_pkg::LIM_FULL;
    drop     = r.off_cnt >> fpc_pkg::RAMP_SHIFT;
    if (drop >= 24'(lim_top - fpc_pkg::LIM_FLOOR))
      lim_now = fpc_pkg::LIM_FLOOR;
    else
      lim_now = lim_top - drop[7:0];
    can_on   = (r.st == fpc_pkg::ST_RUN) && !r.uv_block && !r.therm_block
               && (r.hold == 16'h0000) && r.ctrl[fpc_pkg::CTRL_ENABLE];
    next_r.req_prev = c.cycle_req;

    // Jitter modulation of the limit top
    if (r.jit_cnt >= T_JIT - 16'h0001)
    begin
      next_r.jit_cnt = 16'h0000;
      next_r.jit_lo  = !r.jit_lo;
    end
    else
      next_r.jit_cnt = r.jit_cnt + 16'h0001;

    // Free-running saturating timers
    if (r.off_cnt != CNT_MAX && !r.gate)
      next_r.off_cnt = r.off_cnt + 24'h000001;
    if (r.req_gap != CNT_MAX)
      next_r.req_gap = r.req_gap + 24'h000001;
    if (r.hold != 16'h0000)
      next_r.hold = r.hold - 16'h0001;
    if (!r.gate && r.off_cnt >= T_DISC)
      next_r.line_on = 1'b0;

    // Supply undervoltage lockout
    if (c.supply_low)
      next_r.uv_block = 1'b1;
    else if (c.supply_shunt)
      next_r.uv_block = 1'b0;

    // Hysteretic thermal response
    if (!r.ctrl[fpc_pkg::CTRL_THERM_LATCH])
    begin
      if (c.thermal_trip)
        next_r.therm_block = 1'b1;
      else if (c.thermal_cool)
        next_r.therm_block = 1'b0;
    end
    else
      next_r.therm_block = 1'b0;

    // Request bookkeeping: overload rate and gap
    if (req_edge)
    begin
      next_r.req_gap = 24'h000000;
      if (r.req_gap < T_OVL)
        next_r.ovl_cnt = r.ovl_cnt + r.req_gap;
      else
        next_r.ovl_cnt = 24'h000000;
    end

    // Line brown-out tracking
    if (c.line_brownin)
      next_r.low_seen = 1'b0;
    else if (c.line_brownout)
      next_r.low_seen = 1'b1;
    if (r.low_seen && !c.line_brownin)
    begin
      if (r.low_cnt != CNT_MAX)
        next_r.low_cnt = r.low_cnt + 24'h000001;
    end
    else
      next_r.low_cnt = 24'h000000;

    // Switch on and off
    if (r.gate)
    begin
      if (r.on_cnt != 8'hff)
        next_r.on_cnt = r.on_cnt + 8'h01;
      if (!can_on || r.on_cnt >= T_MAXON)
      begin
        next_r.gate    = 1'b0;
        next_r.off_cnt = 24'h000000;
      end
      else if (c.cur_lim)
      begin
        next_r.gate    = 1'b0;
        next_r.off_cnt = 24'h000000;
        if (SRS_EN && r.on_cnt < LEADING_EDGE_WINDOW)
        begin
          if (r.srs_armed)
          begin
            next_r.st    = fpc_pkg::ST_AROFF;
            next_r.tmr   = T_SHORT;
            next_r.cause = fpc_pkg::CAUSE_SHORT;
          end
          else
          begin
            next_r.hold      = T_SRS;
            next_r.srs_armed = 1'b1;
          end
          next_r.soa_prev = 1'b0;
        end
        else if (r.on_cnt < T_SOA)
        begin
          next_r.srs_armed = 1'b0;
          if (r.soa_prev)
          begin
            next_r.hold     = T_SKIP;
            next_r.soa_prev = 1'b0;
          end
          else
            next_r.soa_prev = 1'b1;
        end
        else
        begin
          next_r.srs_armed = 1'b0;
          next_r.soa_prev  = 1'b0;
        end
      end
    end
    else if (req_edge && can_on)
    begin
      next_r.gate      = 1'b1;
      next_r.on_cnt    = 8'h00;
      next_r.lim_level = lim_now;
      next_r.line_on   = 1'b1;
    end

    // Main sequencer
    case (r.st)
      fpc_pkg::ST_CHARGE:
      begin
        if (c.supply_shunt)
        begin
          next_r.lim_sel = c.cap_large;
          next_r.st      = fpc_pkg::ST_LINECHK;
        end
      end
      fpc_pkg::ST_LINECHK:
      begin
        next_r.line_on = 1'b1;
        if (c.line_brownin && !c.line_ov)
        begin
          next_r.st      = fpc_pkg::ST_RUN;
          next_r.req_gap = 24'h000000;
          next_r.ovl_cnt = 24'h000000;
          next_r.cause   = fpc_pkg::CAUSE_NONE;
        end
      end
      fpc_pkg::ST_RUN:
      begin
        if (c.supply_fault)
        begin
          next_r.cause = fpc_pkg::CAUSE_SUPPLY;
          if (r.ctrl[fpc_pkg::CTRL_FAULT_LATCH])
            next_r.st = fpc_pkg::ST_LATCHED;
          else
          begin
            next_r.st  = fpc_pkg::ST_AROFF;
            next_r.tmr = T_ROFF;
          end
        end
        else if (r.ctrl[fpc_pkg::CTRL_THERM_LATCH] && c.thermal_trip)
        begin
          next_r.st    = fpc_pkg::ST_LATCHED;
          next_r.cause = fpc_pkg::CAUSE_THERMAL;
        end
        else if (c.line_ov || r.low_cnt >= T_LLOW)
        begin
          next_r.st    = fpc_pkg::ST_AROFF;
          next_r.tmr   = T_ROFF;
          next_r.cause = fpc_pkg::CAUSE_LINE;
        end
        else if (r.ovl_cnt >= T_RON)
        begin
          next_r.st    = fpc_pkg::ST_AROFF;
          next_r.tmr   = T_ROFF;
          next_r.cause = fpc_pkg::CAUSE_OVLOAD;
        end
        else if (r.req_gap >= T_LOSS)
        begin
          next_r.st    = fpc_pkg::ST_AROFF;
          next_r.tmr   = T_ROFF;
          next_r.cause = fpc_pkg::CAUSE_REQLOSS;
        end
      end
      fpc_pkg::ST_AROFF:
      begin
        // An input line reset ends the off period at once
        if (c.line_brownout || r.tmr == 25'h0000000)
          next_r.st = fpc_pkg::ST_LINECHK;
        else
          next_r.tmr = r.tmr - 25'h0000001;
      end
      fpc_pkg::ST_LATCHED:
      begin
        if (c.line_brownout)
          next_r.st = fpc_pkg::ST_LINECHK;
      end
      default:
        next_r.st = fpc_pkg::ST_CHARGE;
    endcase

    // Supply collapse is a full power-on restart
    if (c.supply_clear)
    begin
      next_r.st    = fpc_pkg::ST_CHARGE;
      next_r.cause = fpc_pkg::CAUSE_NONE;
    end
    if (next_r.st != fpc_pkg::ST_RUN)
    begin
      next_r.gate      = 1'b0;
      next_r.hold      = 16'h0000;
      next_r.srs_armed = next_r.st == fpc_pkg::ST_RUN;
      // A gate cut by a fault still starts a fresh off-time
      if (r.gate)
        next_r.off_cnt = 24'h000000;
    end

    // Register bus
    status = {8'h00, r.lim_level, 5'h00, r.cause, r.line_on, r.therm_block,
              r.uv_block, r.lim_sel, r.gate, r.st};
    ap_valid = hsel_i && htrans_i[1] && hready_i;
    if (r.d_wr && r.d_addr == fpc_pkg::ADDR_CTRL)
      next_r.ctrl = hwdata_i[2:0];
    next_r.d_wr   = ap_valid && hwrite_i;
    next_r.d_addr = haddr_i[7:0];
    if (ap_valid && !hwrite_i)
    begin
      if (haddr_i[31:8] != 24'h000000)
        next_r.rdata = 32'h00000000;
      else if (haddr_i[7:0] == fpc_pkg::ADDR_CTRL)
        next_r.rdata = {29'h00000000, next_r.ctrl};
      else if (haddr_i[7:0] == fpc_pkg::ADDR_STATUS)
        next_r.rdata = status;
      else
        next_r.rdata = 32'h00000000;
    end
    if (ap_valid && hwrite_i && haddr_i[31:8] != 24'h000000)
      next_r.d_wr = 1'b0;
  end

  // ==========================================================
  // State register
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      r           <= '0;
      r.st        <= fpc_pkg::ST_CHARGE;
      r.ctrl      <= fpc_pkg::CTRL_RESET;
      r.lim_level <= fpc_pkg::LIM_FULL;
      r.uv_block  <= 1'b1;
      r.line_on   <= 1'b1;
    end
    else
      r <= next_r;
  end

  // ==========================================================
  // Outputs
  assign switch_gate_o        = r.gate;
  assign peak_current_limit_o = r.lim_level;
  assign limit_increased_o    = r.lim_sel;
  assign line_sense_on_o      = r.line_on;
  assign hreadyout_o          = 1'b1;
  assign hresp_o              = 1'b0;
  assign hrdata_o             = r.rdata;

  logic unused_hsize;
  assign unused_hsize = ^hsize_i;

endmodule

// *** hw/fpc_pkg.sv ***
// Shared constants and carrier types for the primary switch fault controller
package fpc_pkg;

  // ==========================================================
  // Clock and timing
  localparam int CLK_PERIOD_NS   = 100;
  localparam int LES_WIN_NS      = 200;
  localparam int SOA_WIN_NS      = 500;
  localparam int SRS_OFF_NS      = 30000;
  localparam int SOA_SKIP_NS     = 25000;
  localparam int LINE_DISC_NS    = 50000;
  localparam int OVL_RATE_HZ     = 110000;
  localparam int RESTART_ON_MS   = 82;
  // Windows round down, off times round up
  localparam int LES_WIN_CYC     = LES_WIN_NS / CLK_PERIOD_NS;
  localparam int SOA_WIN_CYC     = SOA_WIN_NS / CLK_PERIOD_NS;
  localparam int SRS_OFF_CYC     = (SRS_OFF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SOA_SKIP_CYC    = (SOA_SKIP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LINE_DISC_CYC   = (LINE_DISC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int OVL_GAP_CYC     = 1000000000 / (OVL_RATE_HZ * CLK_PERIOD_NS);
  localparam int RESTART_ON_CYC  = RESTART_ON_MS * (1000000 / CLK_PERIOD_NS);
  localparam int MAX_ON_CYC      = 200;

  // ==========================================================
  // Current limit shaping, percent of full limit
  localparam logic [7:0] LIM_FULL   = 8'h64;
  localparam logic [7:0] LIM_JITTER = 8'h5f;
  localparam logic [7:0] LIM_FLOOR  = 8'h1e;
  localparam int         RAMP_SHIFT = 5;

  // ==========================================================
  // Register map
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam int CTRL_FAULT_LATCH = 0;
  localparam int CTRL_THERM_LATCH = 1;
  localparam int CTRL_ENABLE      = 2;
  localparam logic [2:0] CTRL_RESET = 3'h4;

  // ==========================================================
  // States and fault causes
  typedef enum logic [2:0] {
    ST_CHARGE  = 3'b000,
    ST_LINECHK = 3'b001,
    ST_RUN     = 3'b010,
    ST_AROFF   = 3'b011,
    ST_LATCHED = 3'b100
  } fpc_state_type;

  localparam logic [2:0] CAUSE_NONE    = 3'h0;
  localparam logic [2:0] CAUSE_SUPPLY  = 3'h1;
  localparam logic [2:0] CAUSE_THERMAL = 3'h2;
  localparam logic [2:0] CAUSE_OVLOAD  = 3'h3;
  localparam logic [2:0] CAUSE_REQLOSS = 3'h4;
  localparam logic [2:0] CAUSE_LINE    = 3'h5;
  localparam logic [2:0] CAUSE_SHORT   = 3'h6;

  // Comparator results from the analog front end
  typedef struct packed {
    logic supply_low;
    logic supply_shunt;
    logic supply_clear;
    logic cap_large;
    logic supply_fault;
    logic thermal_trip;
    logic thermal_cool;
    logic cur_lim;
    logic line_brownout;
    logic line_brownin;
    logic line_ov;
    logic cycle_req;
  } fpc_cmp_type;

endpackage

// *** hw/fpc_sync.sv ***
// Two-stage synchroniser for a vector of asynchronous levels
`timescale 1ns/1ps
module fpc_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         clk_sys_i,
  input  wire logic         rst_i,
  // Levels
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] held;
  } fpc_sync_state_type;

  fpc_sync_state_type r;
  fpc_sync_state_type next_r;

  // ==========================================================
  // Each bit passes two flops; only the second is read outside
  genvar b;
  generate
    for (b = 0; b < W; b++)
    begin : g_bit
      always_comb
      begin
        next_r.meta[b] = async_i[b];
        next_r.held[b] = r.meta[b];
      end
    end
  endgenerate

  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
      r <= '0;
    else
      r <= next_r;
  end

  assign sync_o = r.held;

endmodule

// *** dv/fpc_core_assertions.sv ***
// Port-level assertions for the fault controller core
`timescale 1ns/1ps
module fpc_core_assertions (
  // Clock and reset
  input wire logic                 clk_sys_i,
  input wire logic                 rst_i,
  // Observed ports
  input wire fpc_pkg::fpc_cmp_type cmp_i,
  input wire logic                 switch_gate_o,
  input wire logic [7:0]           peak_current_limit_o,
  input wire logic                 limit_increased_o,
  input wire logic                 line_sense_on_o
);
  default clocking dc @(posedge clk_sys_i);
  endclocking
  default disable iff (rst_i);

  // ==========================================================
  // Run lengths of gate high and gate low
  logic [9:0] on_run;
  logic [9:0] off_run;
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      on_run  <= '0;
      off_run <= '0;
    end
    else
    begin
      on_run  <= switch_gate_o ? on_run + 10'h1 : 10'h0;
      off_run <= switch_gate_o ? 10'h0 : ((&off_run) ? off_run : off_run + 10'h1);
    end
  end

  // ==========================================================
  // Sequences
  // Five samples cover both sync flops, the block register and the gate register
  sequence s_held(b);
    b [*5];
  endsequence
  sequence s_turn_on;
    $rose(switch_gate_o);
  endsequence

  // ==========================================================
  // Properties
  AST_UV_OFF: assert property (s_held(cmp_i.supply_low) |-> !switch_gate_o)
    else $error("gate on with supply low");
  AST_FAULT_OFF: assert property (s_held(cmp_i.supply_fault) |-> !switch_gate_o)
    else $error("gate on with supply fault");
  AST_HOT_OFF: assert property (s_held(cmp_i.thermal_trip) |-> !switch_gate_o)
    else $error("gate on while hot");
  AST_OV_OFF: assert property (s_held(cmp_i.line_ov) |-> !switch_gate_o)
    else $error("gate on with line overvoltage");
  AST_GATE_CAUSE: assert property (s_turn_on |->
    $past(cmp_i.cycle_req, 2) || $past(cmp_i.cycle_req, 3) || $past(cmp_i.cycle_req, 4))
    else $error("gate rose without a request");
  AST_LIM_RANGE: assert property (peak_current_limit_o >= 8'h1e && peak_current_limit_o <= 8'h64)
    else $error("limit out of range");
  AST_LIM_LOAD: assert property ($changed(peak_current_limit_o) |->
    switch_gate_o && on_run < 10'h2)
    else $error("limit changed away from turn-on");
  AST_SENSE_DROP: assert property ($fell(line_sense_on_o) |-> off_run >= 10'h1ef)
    else $error("line sense dropped early");
  AST_SENSE_BACK: assert property (s_turn_on |-> ##[0:1] line_sense_on_o)
    else $error("line sense not back at turn-on");
  AST_INCR_LATCH: assert property ($changed(limit_increased_o) |->
    $past(cmp_i.supply_shunt, 2) || $past(cmp_i.supply_shunt, 3) || $past(cmp_i.supply_shunt, 4))
    else $error("limit selection changed outside charge");
endmodule

bind fpc_core fpc_core_assertions fpc_core_assertions_i (
  .clk_sys_i            (clk_sys_i),
  .rst_i                (rst_i),
  .cmp_i                (cmp_i),
  .switch_gate_o        (switch_gate_o),
  .peak_current_limit_o (peak_current_limit_o),
  .limit_increased_o    (limit_increased_o),
  .line_sense_on_o      (line_sense_on_o)
);

// *** dv/fpc_sec_model.sv ***
// Secondary side model issuing switching cycle requests
`timescale 1ns/1ps
module fpc_sec_model (
  // Clock and reset
  input  wire logic        clk_sys_i,
  input  wire logic        rst_i,
  // Bench control
  input  wire logic        run_i,
  input  wire logic [15:0] gap_i,
  // Request line
  output logic             cycle_req_o
);
  logic [15:0] cnt;

  // A started period always completes, so no pulse is cut short
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
      cnt <= '0;
    else if (cnt != 16'h0 || run_i)
      cnt <= (cnt + 16'h1 >= gap_i) ? 16'h0 : cnt + 16'h1;
  end

  // Three cycles high, then low for the rest of the period
  assign cycle_req_o = (cnt != 16'h0 || run_i) && cnt < 16'h3;
endmodule

// *** dv/fpc_core_tb_top.sv ***
// Self-checking bench for the primary switch fault controller core
`timescale 1ns/1ps
module fpc_core_tb_top;
  // ==========================================================
  // Signals
  logic                 clk_sys_i = 1'b0;
  logic                 rst_i     = 1'b1;
  fpc_pkg::fpc_cmp_type cmp       = '0;
  fpc_pkg::fpc_cmp_type cmp_in;
  logic                 run       = 1'b0;
  logic [15:0]          gap       = 16'h8;
  logic                 req;
  logic                 gate;
  logic                 incr;
  logic                 sense;
  logic [7:0]           lim;
  logic                 hsel      = 1'b0;
  logic [31:0]          haddr     = '0;
  logic [1:0]           htrans    = 2'b00;
  logic                 hwrite    = 1'b0;
  logic [31:0]          hwdata    = '0;
  logic                 hrdy;
  logic [31:0]          hrdata;
  logic                 hresp;
  logic [31:0]          r;
  int                   err_total = 0;
  int                   checked   = 0;
  int                   offs[3]   = '{20, 1000, 2400};
  int                   lo;
  int                   hi;
  localparam int B_SHT = 10, B_CLR = 9, B_FLT = 7, B_HOT = 6;

  // ==========================================================
  // Clock, partner and design
  always #50 clk_sys_i = ~clk_sys_i;

  always_comb
  begin
    cmp_in           = cmp;
    cmp_in.cycle_req = req;
  end

  fpc_sec_model fpc_sec_model_i (
    .clk_sys_i   (clk_sys_i),
    .rst_i       (rst_i),
    .run_i       (run),
    .gap_i       (gap),
    .cycle_req_o (req)
  );

  // Short counts keep the run brief
  fpc_core #(
    .RESTART_ON_CYC  (2000),
    .RESTART_OFF_CYC (500),
    .SHORT_OFF_CYC   (800),
    .REQ_LOSS_CYC    (3000),
    .LINE_LOW_CYC    (400)
  ) fpc_core_i (
    .clk_sys_i            (clk_sys_i),
    .rst_i                (rst_i),
    .cmp_i                (cmp_in),
    .switch_gate_o        (gate),
    .peak_current_limit_o (lim),
    .limit_increased_o    (incr),
    .line_sense_on_o      (sense),
    .hsel_i               (hsel),
    .haddr_i              (haddr),
    .htrans_i             (htrans),
    .hwrite_i             (hwrite),
    .hsize_i              (3'h2),
    .hwdata_i             (hwdata),
    .hready_i             (hrdy),
    .hreadyout_o          (hrdy),
    .hresp_o              (hresp),
    .hrdata_o             (hrdata)
  );

  // ==========================================================
  // Tasks
  task automatic wt(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e)
    begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic chk_in(input string n, input int l, input int h, input logic [31:0] g);
    checked++;
    if ((g >= l && g <= h) !== 1'b1)
    begin
      err_total++;
      $display("CHECK FAILED %s expected %0d..%0d seen %h", n, l, h, g);
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= {24'h0, a};
    hwrite <= w;
    @(posedge clk_sys_i);
    while (hrdy !== 1'b1) @(posedge clk_sys_i);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge clk_sys_i);
    while (hrdy !== 1'b1) @(posedge clk_sys_i);
    r = hrdata;
  endtask

  task automatic st(input logic [2:0] s);
    bus(1'b0, 8'h04, 32'h0);
    chk("state", {29'h0, s}, {29'h0, r[2:0]});
  endtask

  task automatic fire(input int b);
    cmp[b] <= 1'b1;
    wt(6);
    cmp[b] <= 1'b0;
    wt(4);
  endtask

  task automatic shot();
    run <= 1'b1;
    @(posedge clk_sys_i);
    run <= 1'b0;
    wt(10);
  endtask

  // Limit reached a few cycles into the on-time, inside the fast window
  task automatic soa();
    run <= 1'b1;
    wt(4);
    run <= 1'b0;
    cmp.cur_lim <= 1'b1;
    wt(6);
    cmp.cur_lim <= 1'b0;
    wt(4);
  endtask

  // Late enough in the on-time to stay clear of the short guards
  task automatic stop();
    cmp.cur_lim <= 1'b1;
    wt(6);
    cmp.cur_lim <= 1'b0;
    wt(2);
  endtask

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // ==========================================================
  // Tests
  initial
  begin
    wt(4);
    rst_i <= 1'b0;
    @(posedge clk_sys_i);
    chk("outputs", 32'h321, {lim, gate, incr, sense});
    bus(1'b0, 8'h00, 32'h0);
    chk("ctrl", 32'h4, r);
    chk("resp", 32'h0, {31'h0, hresp});
    bus(1'b1, 8'h08, 32'hff);
    bus(1'b0, 8'h08, 32'h0);
    chk("unmapped", 32'h0, r);
    bus(1'b1, 8'h04, 32'h7);
    st(3'h0);
    cmp.cap_large <= 1'b1;
    fire(B_SHT);
    cmp.cap_large <= 1'b0;
    st(3'h1);
    chk("increased", 32'h1, incr);
    shot();
    chk("gate", 32'h0, gate);
    cmp.line_brownin <= 1'b1;
    wt(6);
    st(3'h2);
    $display("test power-up done");
    shot();
    foreach (offs[i])
    begin
      stop();
      wt(offs[i]);
      if (offs[i] > 600)
        chk("sense off", 32'h0, sense);
      shot();
      lo = 95 - (offs[i] + 12) / 32;
      hi = 100 - offs[i] / 32;
      chk_in("limit", (lo < 30) ? 30 : lo, (hi < 30) ? 30 : hi, lim);
      chk("sense on", 32'h1, sense);
    end
    $display("test limit ramp done");
    cmp.supply_low <= 1'b1;
    wt(6);
    chk("gate", 32'h0, gate);
    shot();
    chk("gate", 32'h0, gate);
    cmp.supply_low <= 1'b0;
    wt(4);
    shot();
    chk("gate", 32'h0, gate);
    fire(B_SHT);
    shot();
    chk("gate", 32'h1, gate);
    stop();
    fire(B_HOT);
    shot();
    chk("gate", 32'h0, gate);
    cmp.thermal_cool <= 1'b1;
    wt(4);
    shot();
    chk("gate", 32'h1, gate);
    cmp.thermal_cool <= 1'b0;
    stop();
    bus(1'b1, 8'h00, 32'h6);
    fire(B_HOT);
    cmp.thermal_cool <= 1'b1;
    wt(4);
    shot();
    chk("gate", 32'h0, gate);
    st(3'h4);
    cmp.thermal_cool <= 1'b0;
    cmp.line_brownin <= 1'b0;
    cmp.line_brownout <= 1'b1;
    wt(6);
    st(3'h1);
    cmp.line_brownout <= 1'b0;
    cmp.line_brownin <= 1'b1;
    wt(6);
    st(3'h2);
    $display("test blocks done");
    for (int m = 0; m < 2; m++)
    begin
      bus(1'b1, 8'h00, 32'h4 + m);
      fire(B_FLT);
      st(m ? 3'h4 : 3'h3);
      chk("cause", 32'h1, {29'h0, r[10:8]});
      if (m == 0)
      begin
        wt(400);
        st(3'h3);
        wt(200);
        st(3'h2);
      end
    end
    fire(B_CLR);
    st(3'h0);
    fire(B_SHT);
    st(3'h2);
    bus(1'b1, 8'h00, 32'h4);
    cmp.line_ov <= 1'b1;
    wt(6);
    st(3'h3);
    chk("cause", 32'h5, {29'h0, r[10:8]});
    wt(600);
    st(3'h1);
    cmp.line_ov <= 1'b0;
    wt(6);
    st(3'h2);
    wt(3100);
    st(3'h3);
    chk("cause", 32'h4, {29'h0, r[10:8]});
    wt(600);
    st(3'h2);
    cmp.line_brownin  <= 1'b0;
    cmp.line_brownout <= 1'b1;
    wt(6);
    cmp.line_brownout <= 1'b0;
    wt(300);
    st(3'h2);
    wt(200);
    st(3'h3);
    chk("cause", 32'h5, {29'h0, r[10:8]});
    wt(600);
    st(3'h1);
    cmp.line_brownin <= 1'b1;
    wt(6);
    st(3'h2);
    $display("test faults done");
    cmp.cur_lim <= 1'b1;
    shot();
    wt(100);
    shot();
    chk("gate", 32'h0, gate);
    wt(250);
    shot();
    st(3'h3);
    chk("cause", 32'h6, {29'h0, r[10:8]});
    cmp.cur_lim <= 1'b0;
    wt(650);
    st(3'h3);
    wt(250);
    st(3'h2);
    soa();
    soa();
    shot();
    chk("gate", 32'h0, gate);
    wt(250);
    shot();
    chk("gate", 32'h1, gate);
    gap <= 16'h3c;
    run <= 1'b1;
    wt(2300);
    run <= 1'b0;
    st(3'h3);
    chk("cause", 32'h3, {29'h0, r[10:8]});
    $display("test short and overload done");
    test_done();
  end

  // Whole sequence needs about 14000 cycles
  initial
  begin
    wt(40000);
    err_total++;
    test_done();
  end
endmodule
